// ===== rtl/rco_cfg.svh
`ifndef RCO_CFG_SVH
`define RCO_CFG_SVH

// Register byte offsets
`define RCO_CTRL_OFF 12'h000
`define RCO_VLAN_OFF 12'h004
`define RCO_CSUM_OFF 12'h008
`define RCO_COUNT_OFF 12'h00c
`define RCO_STATE_OFF 12'h010

// Control fields and reset values
`define RCO_CTRL_EN_BIT 0
`define RCO_CTRL_MODE_BIT 1
`define RCO_CTRL_RST 2'h0
`define RCO_VLAN_RST 16'h8100

// Header layout, in bytes
`define RCO_MAC_HDR_LAST 4'hd
`define RCO_ADDR_LAST 4'hb
`define RCO_TAG_CTRL_LEN 4'h2
`define RCO_SNAP_LEN 4'h8
`define RCO_LEN_MAX 16'h05dc
`define RCO_VLAN_MAX 2
`define RCO_CSUM_BYTES 2

`endif

// ===== rtl/rco_pkg.sv
package rco_pkg;

    typedef enum logic [6:0] {
        RCO_ST_IDLE = 7'h01,
        RCO_ST_PASS = 7'h02,
        RCO_ST_HDR = 7'h04,
        RCO_ST_TYPE = 7'h08,
        RCO_ST_SKIP = 7'h10,
        RCO_ST_SUM = 7'h20,
        RCO_ST_APP = 7'h40
    } rco_state_t;

endpackage : rco_pkg

// ===== rtl/rco_csum_acc.sv
`timescale 1ns/1ps
module rco_csum_acc #(
    parameter bit FIRST_HIGH = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [15:0] sum,
    output logic odd
);
    logic [15:0] acc_reg;
    logic [7:0] pend_reg;
    logic odd_reg;

    function automatic logic [15:0] fold(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] raw;
        raw = {1'b0, a} + {1'b0, b};
        fold = raw[15:0] + {15'h0000, raw[16]};
    endfunction : fold

    wire [15:0] word = FIRST_HIGH ? {pend_reg, data} : {data, pend_reg};
    wire [15:0] acc_next = fold(acc_reg, word);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 16'h0000;
            pend_reg <= 8'h00;
            odd_reg <= 1'b0;
        end else if (clr) begin
            acc_reg <= 16'h0000;
            pend_reg <= 8'h00;
            odd_reg <= 1'b0;
        end else if (add) begin
            acc_reg <= odd_reg ? acc_next : acc_reg;
            pend_reg <= odd_reg ? pend_reg : data;
            odd_reg <= ~odd_reg;
        end
    end

    // Lone last byte sits low under a zero upper byte
    assign sum = odd_reg ? fold(acc_reg, {8'h00, pend_reg}) : acc_reg;
    assign odd = odd_reg;
endmodule : rco_csum_acc

// ===== rtl/rco_len_adj.sv
`timescale 1ns/1ps
`include "rco_cfg.svh"
module rco_len_adj #(
    parameter int LEN_W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [LEN_W-1:0] in_len,
    input wire logic add_csum,
    output logic out_valid,
    output logic [LEN_W-1:0] out_len
);
    localparam logic [LEN_W-1:0] CSUM_LEN = LEN_W'(`RCO_CSUM_BYTES);

    if (LEN_W < 4 || LEN_W > 16) begin : g_bad_len_w
        $error("rco_len_adj: LEN_W must be 4..16");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_len <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_len <= add_csum ? in_len + CSUM_LEN : in_len;
            end
        end
    end
endmodule : rco_len_adj

// ===== rtl/rco_rx_checksum_engine.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "rco_cfg.svh"
//Behaviour
// R01 - Disabled: forward bytes unchanged, no checksum
// R02 - Two modes chosen by one select bit
// R03 - Mode 0 sums after 14 bytes, before FCS
// R04 - Mode 1 skips VLAN, SNAP; sums from L3
// R05 - VLAN recognised by programmable type, default 8100h
// R06 - At most two tags; third acts as type
// R07 - Sum on the fly, appended after last byte
// R08 - Status length grows by two when appended
// R09 - Sum 16-bit words, odd tail zero padded
// R10 - Even count: second byte high, carries folded
// R11 - Odd count: first byte high, tail low
// R12 - Software quiesces reception before control changes
// R13 - Software keeps pad stripping off while enabled
// R14 - Sum and parse state cleared each frame
module rco_rx_checksum_engine #(
    parameter int VLAN_MAX = `RCO_VLAN_MAX,
    parameter int LEN_W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    input wire logic in_fcs,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic sts_in_valid,
    input wire logic [LEN_W-1:0] sts_in_len,
    output logic sts_valid,
    output logic [LEN_W-1:0] sts_len
);
    import rco_pkg::*;

    if (VLAN_MAX < 1 || VLAN_MAX > 3) begin : g_bad_vlan_max
        $error("rco_rx_checksum_engine: VLAN_MAX must be 1..3");
    end

    if (LEN_W < 4 || LEN_W > 16) begin : g_bad_len_w
        $error("rco_rx_checksum_engine: LEN_W must be 4..16");
    end

    // Register file
    logic rx_csum_enable_reg;
    logic rx_csum_mode_select_reg;
    logic [15:0] vlan_tag_type_value_reg;
    logic [15:0] last_csum_reg;
    logic [15:0] frame_count_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    // Stream state
    rco_state_t state_reg;
    rco_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [1:0] vlan_cnt_reg;
    logic [1:0] vlan_cnt_next;
    logic [7:0] type_hi_reg;
    logic skip_to_type_reg;
    logic skip_to_type_next;
    logic frame_en_reg;
    logic frame_mode_reg;
    logic app_hi_reg;
    logic appended_reg;
    logic out_valid_reg;
    logic [7:0] out_data_reg;
    logic out_last_reg;
    logic [15:0] sum_even;
    logic [15:0] sum_odd;
    logic odd_count;

    // APB decode
    wire setup = psel & ~penable;
    wire wr_access = psel & penable & pwrite;
    wire sel_ctrl = paddr == `RCO_CTRL_OFF;
    wire sel_vlan = paddr == `RCO_VLAN_OFF;
    wire sel_csum = paddr == `RCO_CSUM_OFF;
    wire sel_count = paddr == `RCO_COUNT_OFF;
    wire sel_state = paddr == `RCO_STATE_OFF;
    wire addr_hit = sel_ctrl | sel_vlan | sel_csum | sel_count | sel_state;
    wire [31:0] ctrl_word = {30'h00000000, rx_csum_mode_select_reg, rx_csum_enable_reg};
    wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                          sel_vlan ? {16'h0000, vlan_tag_type_value_reg} :
                          sel_csum ? {16'h0000, last_csum_reg} :
                          sel_count ? {16'h0000, frame_count_reg} :
                          sel_state ? {25'h0000000, state_reg} :
                          32'h00000000;

    // Zero wait states: read data is latched in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg & psel & penable;

    // Software must quiesce reception before changing these
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_csum_enable_reg <= 1'(`RCO_CTRL_RST >> `RCO_CTRL_EN_BIT);
            rx_csum_mode_select_reg <= 1'(`RCO_CTRL_RST >> `RCO_CTRL_MODE_BIT);
        end else if (wr_access & sel_ctrl) begin
            rx_csum_enable_reg <= pwdata[`RCO_CTRL_EN_BIT]; // R01
            rx_csum_mode_select_reg <= pwdata[`RCO_CTRL_MODE_BIT]; // R02
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vlan_tag_type_value_reg <= `RCO_VLAN_RST; // R05
        end else if (wr_access & sel_vlan) begin
            vlan_tag_type_value_reg <= pwdata[15:0]; // R05
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_word;
            pslverr_reg <= ~addr_hit;
        end
    end

    // Stream handshake
    wire in_state_app = state_reg == RCO_ST_APP;
    assign in_ready = ~in_state_app;
    wire take = in_valid & in_ready;
    // First byte restarts all per-frame state
    wire sof = take & (state_reg == RCO_ST_IDLE);

    // Controls take effect at frame start only
    wire cur_en = sof ? rx_csum_enable_reg : frame_en_reg;
    wire cur_mode = sof ? rx_csum_mode_select_reg : frame_mode_reg;
    wire go_app = take & in_last & cur_en; // R07
    wire app_done = in_state_app & app_hi_reg;

    wire [15:0] type_word = {type_hi_reg, in_data};
    wire is_vlan = type_word == vlan_tag_type_value_reg; // R05
    // Past the tag limit a matching value acts as the type
    wire vlan_room = 32'(vlan_cnt_reg) < VLAN_MAX;
    // Small type values are lengths: LLC and SNAP follow
    wire is_length = type_word <= `RCO_LEN_MAX;
    wire add_byte = take & (state_reg == RCO_ST_SUM) & ~in_fcs; // R03
    wire [15:0] csum = odd_count ? sum_odd : sum_even;

    // Header parser
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        vlan_cnt_next = vlan_cnt_reg;
        skip_to_type_next = skip_to_type_reg;
        if (take) begin
            case (state_reg)
                RCO_ST_IDLE: begin
                    cnt_next = 4'h1;
                    vlan_cnt_next = 2'h0; // R14
                    skip_to_type_next = 1'b0;
                    state_next = cur_en ? RCO_ST_HDR : RCO_ST_PASS; // R01
                end
                RCO_ST_HDR: begin
                    cnt_next = cnt_reg + 4'h1;
                    if (!cur_mode && cnt_reg == `RCO_MAC_HDR_LAST) begin
                        state_next = RCO_ST_SUM; // R03
                    end else if (cur_mode && cnt_reg == `RCO_ADDR_LAST) begin
                        state_next = RCO_ST_TYPE; // R04
                        cnt_next = 4'h0;
                    end
                end
                RCO_ST_TYPE: begin
                    cnt_next = 4'h1;
                    if (cnt_reg != 4'h0) begin
                        if (is_vlan && vlan_room) begin
                            vlan_cnt_next = vlan_cnt_reg + 2'h1; // R06
                            cnt_next = `RCO_TAG_CTRL_LEN;
                            skip_to_type_next = 1'b1;
                            state_next = RCO_ST_SKIP;
                        end else if (is_length && !is_vlan) begin
                            cnt_next = `RCO_SNAP_LEN; // R04
                            skip_to_type_next = 1'b0;
                            state_next = RCO_ST_SKIP;
                        end else begin
                            state_next = RCO_ST_SUM; // R06
                        end
                    end
                end
                RCO_ST_SKIP: begin
                    cnt_next = cnt_reg - 4'h1;
                    if (cnt_reg == 4'h1) begin
                        cnt_next = 4'h0;
                        state_next = skip_to_type_reg ? RCO_ST_TYPE : RCO_ST_SUM;
                    end
                end
                RCO_ST_PASS: begin
                    state_next = RCO_ST_PASS;
                end
                RCO_ST_SUM: begin
                    state_next = RCO_ST_SUM;
                end
                default: begin
                    state_next = RCO_ST_IDLE;
                end
            endcase
            // A frame may end inside the header
            if (in_last) begin
                state_next = go_app ? RCO_ST_APP : RCO_ST_IDLE; // R07
            end
        end else if (app_done) begin
            state_next = RCO_ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RCO_ST_IDLE;
            cnt_reg <= 4'h0;
            vlan_cnt_reg <= 2'h0;
            skip_to_type_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            vlan_cnt_reg <= vlan_cnt_next;
            skip_to_type_reg <= skip_to_type_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_hi_reg <= 8'h00;
        end else if (take & (state_reg == RCO_ST_TYPE) & (cnt_reg == 4'h0)) begin
            type_hi_reg <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_en_reg <= 1'b0;
            frame_mode_reg <= 1'b0;
        end else if (sof) begin
            frame_en_reg <= rx_csum_enable_reg;
            frame_mode_reg <= rx_csum_mode_select_reg;
        end
    end

    // Two accumulators run in parallel since parity is known only at the end
    rco_csum_acc #(
        .FIRST_HIGH(1'b0)
    ) u_acc_even (
        .pclk(pclk),
        .presetn(presetn),
        .clr(sof),
        .add(add_byte),
        .data(in_data),
        .sum(sum_even),
        .odd(odd_count)
    ); // R10

    rco_csum_acc #(
        .FIRST_HIGH(1'b1)
    ) u_acc_odd (
        .pclk(pclk),
        .presetn(presetn),
        .clr(sof),
        .add(add_byte),
        .data(in_data),
        .sum(sum_odd),
        .odd()
    ); // R11

    // Checksum goes out low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_hi_reg <= 1'b0;
        end else begin
            app_hi_reg <= in_state_app & ~app_hi_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= 8'h00;
            out_last_reg <= 1'b0;
        end else begin
            out_valid_reg <= take | in_state_app; // R01
            out_last_reg <= (take & in_last & ~cur_en) | app_done; // R07
            if (in_state_app) begin
                out_data_reg <= app_hi_reg ? csum[15:8] : csum[7:0]; // R09
            end else if (take) begin
                out_data_reg <= in_data; // R01
            end
        end
    end

    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
    assign out_last = out_last_reg;

    // Counts only frames that carried a checksum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_csum_reg <= 16'h0000;
            frame_count_reg <= 16'h0000;
        end else if (app_done) begin
            last_csum_reg <= csum;
            frame_count_reg <= frame_count_reg + 16'h0001;
        end
    end

    // Holds until the next frame starts, covering late status words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            appended_reg <= 1'b0;
        end else if (sof) begin
            appended_reg <= rx_csum_enable_reg;
        end
    end

    rco_len_adj #(
        .LEN_W(LEN_W)
    ) u_len_adj (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(sts_in_valid),
        .in_len(sts_in_len),
        .add_csum(appended_reg),
        .out_valid(sts_valid),
        .out_len(sts_len)
    ); // R08

    // Limitation: pad stripping upstream corrupts the sum; not detected here
endmodule : rco_rx_checksum_engine

// ===== verification/rco_asserts.sv
`timescale 1ns/1ps
module rco_chk #(
    parameter int LEN_W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic sts_in_valid,
    input wire logic [LEN_W-1:0] sts_in_len,
    input wire logic sts_valid,
    input wire logic [LEN_W-1:0] sts_len
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire take = in_valid & in_ready;
    wire ctrl_wr = psel & penable & pwrite & pready & (paddr == 12'h000);
    logic en_reg;
    logic busy_reg;
    logic fen_reg;
    // Enable is latched per frame, so track frame start here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
            busy_reg <= 1'b0;
            fen_reg <= 1'b0;
        end else begin
            if (ctrl_wr)
                en_reg <= pwdata[0];
            if (take)
                busy_reg <= !in_last;
            if (take && !busy_reg)
                fen_reg <= en_reg;
        end
    end
    wire en_now = busy_reg ? fen_reg : en_reg;
    a_byte_forward: assert property (take |=> out_valid && out_data == $past(in_data))
        else $error("byte not forwarded");
    a_append_gap: assert property (take && in_last && en_now |=> !in_ready [*2] ##1 in_ready)
        else $error("append stall wrong");
    a_append_last: assert property (take && in_last && en_now |-> ##3 out_valid && out_last)
        else $error("append end wrong");
    a_plain_last: assert property (take && in_last && !en_now |=> out_last && in_ready)
        else $error("disabled frame appended");
    a_ready_cause: assert property ($fell(in_ready) |-> $past(take && in_last))
        else $error("stall without frame end");
    a_sts_pulse: assert property (sts_in_valid |=> sts_valid)
        else $error("status not passed on");
    a_sts_length: assert property (sts_valid |-> sts_len == $past(sts_in_len) + {fen_reg, 1'b0})
        else $error("status length wrong");
    a_err_unmapped: assert property (psel && penable && (paddr > 12'h010 || paddr[1:0] != 2'b00)
        |-> pslverr)
        else $error("no error on unmapped");
    a_err_mapped: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00
        |-> !pslverr)
        else $error("error on mapped");
    c_append: cover property (take && in_last && en_now);
    c_plain: cover property (take && in_last && !en_now);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule : rco_chk

bind rco_rx_checksum_engine rco_chk #(.LEN_W(LEN_W)) u_rco_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .sts_in_valid(sts_in_valid), .sts_in_len(sts_in_len),
    .sts_valid(sts_valid), .sts_len(sts_len));

// ===== verification/rco_mac_model.sv
`timescale 1ns/1ps
module rco_mac_model (
    input wire logic pclk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    output logic in_last,
    output logic in_fcs
);
    logic [7:0] q[$];
    bit lq[$];
    bit fq[$];
    bit slow = 1'b0;
    initial begin
        in_valid = 1'b0;
        in_data = 8'h00;
        in_last = 1'b0;
        in_fcs = 1'b0;
    end
    task automatic send();
        int n;
        n = q.size();
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1;
            in_data <= q[i];
            in_last <= lq[i];
            in_fcs <= fq[i];
            do @(posedge pclk); while (in_ready !== 1'b1);
            if (slow || i == n - 1) begin
                in_valid <= 1'b0;
                // Released bus shows no stale byte
                in_data <= ~q[i];
                in_last <= 1'b0;
                in_fcs <= 1'b0;
                @(posedge pclk);
            end
        end
        q.delete();
        lq.delete();
        fq.delete();
    endtask : send
endmodule : rco_mac_model

// ===== verification/tb_rco_rx_checksum_engine.sv
`timescale 1ns/1ps
module tb_rco_rx_checksum_engine;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic in_valid, in_last, in_fcs, in_ready, out_valid, out_last, sts_in_valid, sts_valid;
    logic [7:0] in_data, out_data;
    logic [13:0] sts_in_len, sts_len;
    logic [7:0] frm[$];
    logic [8:0] exp_q[$];
    logic [8:0] oq[$];
    logic [15:0] last_sum;
    int last_len, cyc;
    int n_errors = 0;
    int compares = 0;
    always #12.5 pclk = ~pclk;
    rco_rx_checksum_engine u_rco_rx_checksum_engine (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
        .in_data(in_data), .in_last(in_last), .in_fcs(in_fcs), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .sts_in_valid(sts_in_valid), .sts_in_len(sts_in_len), .sts_valid(sts_valid),
        .sts_len(sts_len));
    rco_mac_model u_rco_mac_model (.pclk(pclk), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data), .in_last(in_last), .in_fcs(in_fcs));
    always @(posedge pclk) begin
        cyc++;
        if (out_valid === 1'b1)
            oq.push_back({out_last, out_data});
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task report_and_stop();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic reg_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : reg_chk
    task automatic hdr(input logic [15:0] ty);
        frm.delete();
        for (int i = 0; i < 12; i++)
            frm.push_back(8'h10 + 8'(i));
        frm.push_back(ty[15:8]);
        frm.push_back(ty[7:0]);
    endtask : hdr
    task automatic w16(input logic [15:0] v);
        frm.push_back(v[15:8]);
        frm.push_back(v[7:0]);
    endtask : w16
    task automatic pay(input int n);
        // High bytes force carries out of the sum
        for (int i = 0; i < n; i++)
            frm.push_back(8'hc3 + 8'(i * 37));
    endtask : pay
    function automatic logic [15:0] ref_sum(input int st);
        logic [16:0] a;
        logic [15:0] w;
        int e;
        a = 17'h0;
        e = frm.size();
        for (int i = st; i < e; i += 2) begin
            if (i + 1 == e)
                w = {8'h00, frm[i]};
            else if ((e - st) % 2 == 0)
                w = {frm[i+1], frm[i]};
            else
                w = {frm[i], frm[i+1]};
            a = {1'b0, a[15:0]} + {1'b0, w} + {16'h0, a[16]};
        end
        return a[15:0] + {15'h0, a[16]};
    endfunction : ref_sum
    task automatic add_frame(input logic en, input int st);
        logic [7:0] b;
        for (int i = 0; i < frm.size() + 4; i++) begin
            b = (i < frm.size()) ? frm[i] : 8'ha0 + 8'(i);
            u_rco_mac_model.q.push_back(b);
            u_rco_mac_model.lq.push_back(i == frm.size() + 3);
            u_rco_mac_model.fq.push_back(i >= frm.size());
            exp_q.push_back({!en && i == frm.size() + 3, b});
        end
        last_sum = ref_sum(st);
        last_len = frm.size() + 4;
        if (en) begin
            exp_q.push_back({1'b0, last_sum[7:0]});
            exp_q.push_back({1'b1, last_sum[15:8]});
        end
    endtask : add_frame
    task automatic flush(input logic en);
        u_rco_mac_model.send();
        repeat (4) @(posedge pclk);
        check(oq.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < oq.size(); i++)
            check(oq[i], exp_q[i]);
        sts_in_valid <= 1'b1;
        sts_in_len <= 14'(last_len);
        @(posedge pclk);
        sts_in_valid <= 1'b0;
        #1;
        check(sts_valid, 1'b1);
        check(sts_len, 14'(last_len + (en ? 2 : 0)));
        @(posedge pclk);
        oq.delete();
        exp_q.delete();
    endtask : flush
    task automatic t_mode0();
        wr(12'h000, 32'h1);
        hdr(16'h8100);
        pay(6);
        add_frame(1'b1, 14);
        hdr(16'h0800);
        pay(1);
        add_frame(1'b1, 14);
        hdr(16'h0800);
        pay(5);
        add_frame(1'b1, 14);
        flush(1'b1);
        reg_chk(12'h008, {16'h0, last_sum}, 1'b0);
        $display("mode 0 done");
    endtask : t_mode0
    task automatic t_mode1();
        wr(12'h000, 32'h3);
        hdr(16'h8100);
        w16(16'h0005);
        w16(16'h8100);
        w16(16'h0007);
        w16(16'h0800);
        pay(5);
        add_frame(1'b1, 22);
        hdr(16'h8100);
        w16(16'h0001);
        w16(16'h8100);
        w16(16'h0002);
        w16(16'h8100);
        pay(4);
        add_frame(1'b1, 22);
        hdr(16'h05dc);
        pay(12);
        add_frame(1'b1, 22);
        hdr(16'h05dd);
        pay(3);
        add_frame(1'b1, 14);
        u_rco_mac_model.slow = 1'b1;
        flush(1'b1);
        u_rco_mac_model.slow = 1'b0;
        wr(12'h004, 32'h88a8);
        hdr(16'h88a8);
        w16(16'h0009);
        w16(16'h0040);
        pay(10);
        add_frame(1'b1, 26);
        hdr(16'h8100);
        pay(3);
        add_frame(1'b1, 14);
        flush(1'b1);
        wr(12'h000, 32'h2);
        hdr(16'h0800);
        pay(4);
        add_frame(1'b0, 14);
        flush(1'b0);
        reg_chk(12'h00c, 32'h9, 1'b0);
        reg_chk(12'h010, 32'h1, 1'b0);
        $display("mode 1 done");
    endtask : t_mode1
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sts_in_valid = 1'b0;
        sts_in_len = 14'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_chk(12'h000, 32'h0, 1'b0);
        reg_chk(12'h004, 32'h8100, 1'b0);
        reg_chk(12'h014, 32'h0, 1'b1);
        hdr(16'h0800);
        pay(5);
        add_frame(1'b0, 14);
        flush(1'b0);
        $display("disabled done");
        t_mode0();
        t_mode1();
        report_and_stop();
    end
endmodule : tb_rco_rx_checksum_engine
